// file: src/timer_counter_defs.vh
// Register offsets, field positions, reset values and codes of the up/down timer counter.
`ifndef TIMER_COUNTER_DEFS_VH
`define TIMER_COUNTER_DEFS_VH

`define OFS_CLK 12'h000
`define OFS_CTL 12'h004
`define OFS_MAX 12'h008
`define OFS_CNT 12'h00C
`define OFS_STAT 12'h010

`define CLK_SRC_LSB 0
`define CLK_SRC_MSB 2
`define CLK_DIV_LSB 4
`define CLK_DIV_MSB 7
`define CLK_DBG_BIT 8

`define CTL_EN_BIT 0
`define CTL_PRESET_BIT 1
`define CTL_RUN_BIT 2
`define CTL_DIR_LSB 4
`define CTL_DIR_MSB 5
`define CTL_ONE_BIT 6
`define CTL_PEND_BIT 8

`define STAT_ACTIVE_BIT 0
`define STAT_UP_BIT 1

`define SRC_INTERNAL 3'h0
`define SRC_EXT_RISE 3'h1
`define SRC_EXT_FALL 3'h2

`define DIR_UP 2'h0
`define DIR_DOWN 2'h1
`define DIR_UPDOWN 2'h2

`define RST_SRC 3'h0
`define RST_DIV 4'h0
`define RST_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001
`define DUMMY_EDGES 2'h2

`endif

// file: src/count_tick_gen.v
// Count clock generator: internal prescaler or external event edges with dummy edges.
`timescale 1ns/1ps
module count_tick_gen (
  input wire pclk,
  input wire presetn,
  input wire gate,
  input wire start,
  input wire [2:0] clock_source_select,
  input wire [3:0] clock_divider_select,
  input wire external_event_input,
  output reg tick
);
`include "timer_counter_defs.vh"

  reg [14:0] prescale_reg;
  reg ext_prev_reg;
  reg [1:0] dummy_reg;
  wire use_ext;
  wire ext_level;
  wire ext_edge;
  wire [14:0] div_mask;

  function [14:0] mask_of;
    input [3:0] div;
    begin
      mask_of = (div >= 4'hF) ? 15'h7FFF : (15'h7FFF >> (4'hF - div));
    end
  endfunction

  assign use_ext = (clock_source_select == `SRC_EXT_RISE) || (clock_source_select == `SRC_EXT_FALL);
  assign ext_level = (clock_source_select == `SRC_EXT_FALL) ? ~external_event_input : external_event_input;
  assign ext_edge = ext_level & ~ext_prev_reg;
  assign div_mask = mask_of(clock_divider_select);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_reg <= 15'h0000;
      ext_prev_reg <= 1'b0;
      dummy_reg <= 2'h0;
      tick <= 1'b0;
    end else begin
      ext_prev_reg <= ext_level;
      tick <= 1'b0;
      if (!gate) begin
        prescale_reg <= 15'h0000;
      end else if (use_ext) begin
        if (ext_edge) begin
          if (dummy_reg < `DUMMY_EDGES) begin
            dummy_reg <= dummy_reg + 2'h1;
          end else begin
            tick <= 1'b1;
          end
        end
      end else begin
        prescale_reg <= prescale_reg + 15'h0001;
        tick <= ((prescale_reg & div_mask) == div_mask);
      end
      // A new start re-arms the two dummy edges, whatever the gate does.
      if (start) begin
        dummy_reg <= 2'h0;
      end
    end
  end

endmodule

// file: src/max_update_sync.v
// MAX value holder: written value waits for take (the next count tick, or any cycle while idle) before it is used.
`timescale 1ns/1ps
module max_update_sync (
  input wire pclk,
  input wire presetn,
  input wire wr,
  input wire [15:0] wdata,
  input wire take,
  output reg [15:0] max_written,
  output reg [15:0] max_active,
  output reg max_update_pending
);
`include "timer_counter_defs.vh"

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_written <= `RST_MAX;
      max_active <= `RST_MAX;
      max_update_pending <= 1'b0;
    end else begin
      if (wr) begin
        max_written <= wdata;
        max_update_pending <= 1'b1;
      end else if (max_update_pending && take) begin
        max_active <= max_written;
        max_update_pending <= 1'b0;
      end
    end
  end

endmodule

// file: src/updown_timer_counter_block.v
// Up/down timer counter channel with APB register access.
//
// Contract
// - In debug halt with keep-going bit 0, count ticks stop, the count holds and the prescaler clears.
// - With keep-going bit 1, counting continues during debug halt.
// - External source counts each rising edge of the event input.
// - Inverted external source counts falling edges of the event input.
// - First two external edges after start are dummies; the other side supplies them.
// - Nothing runs or starts until the module enable bit is 1.
// - Two-bit direction field plus single-pass bit give six count modes.
// - Sixteen-bit MAX bounds the counter to 0x0000 through MAX.
// - Preset clears counter in up and up/down, loads MAX in down.
// - Writing run 1 starts counting; stopping depends on the mode.
// - Busy reads 1 while running; direction reads 1 counting up.
// - Repeat up wraps to 0x0000 past MAX until run is cleared.
// - Counting up, a MAX below the count clears it to 0x0000.
// - One-shot up wraps to 0x0000 past MAX and stops.
// - Repeat down reloads MAX on underflow until run is cleared.
// - Down counting ignores a new MAX until the next underflow reload.
// - One-shot down reloads MAX on underflow and stops.
// - Repeat up/down alternates 0x0000 to MAX and back until stopped.
// - Up/down MAX change in the down phase waits for 0x0000 first.
// - One-shot up/down stops on reaching 0x0000 going down.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module updown_timer_counter_block (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire external_event_input,
  input wire debug_halt,
  output reg [15:0] current_count,
  output reg counter_active,
  output reg count_up
);
`include "timer_counter_defs.vh"

  localparam [4:0] HIT_CLK = 5'h01;
  localparam [4:0] HIT_CTL = 5'h02;
  localparam [4:0] HIT_MAX = 5'h04;
  localparam [4:0] HIT_CNT = 5'h08;
  localparam [4:0] HIT_STAT = 5'h10;
  localparam [4:0] HIT_NONE = 5'h00;

  reg [2:0] clock_source_select;
  reg [3:0] clock_divider_select;
  reg keep_going_in_debug;
  reg module_enable;
  reg [1:0] count_direction_mode;
  reg single_pass_select;
  reg [15:0] count_next;
  reg up_next;
  reg active_next;
  reg [31:0] rdata_next;
  reg [2:0] clock_source_select_next;
  reg [3:0] clock_divider_select_next;
  reg keep_going_in_debug_next;
  reg module_enable_next;
  reg [1:0] count_direction_mode_next;
  reg single_pass_select_next;
  reg [15:0] load_count_next;
  reg load_up_next;
  reg busy_next;

  wire setup_phase;
  wire access_done;
  wire [4:0] hit;
  wire wr_clk;
  wire wr_ctl;
  wire wr_max;
  wire preset_req;
  wire run_set;
  wire run_clear;
  wire start_pulse;
  wire tick_gate;
  wire tick;
  wire [15:0] max_written;
  wire [15:0] max_active;
  wire max_update_pending;
  wire enable_field;
  wire [1:0] dir_field;
  wire single_field;
  wire [2:0] src_field;
  wire [3:0] div_field;
  wire keep_field;

  function [4:0] decode;
    input [11:0] addr;
    begin
      case (addr)
        `OFS_CLK: decode = HIT_CLK;
        `OFS_CTL: decode = HIT_CTL;
        `OFS_MAX: decode = HIT_MAX;
        `OFS_CNT: decode = HIT_CNT;
        `OFS_STAT: decode = HIT_STAT;
        default: decode = HIT_NONE;
      endcase
    end
  endfunction

  // Read data is sampled in the setup cycle so that prdata leaves a flip-flop.
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign hit = decode(paddr);
  assign wr_clk = access_done & pwrite & (hit == HIT_CLK);
  assign wr_ctl = access_done & pwrite & (hit == HIT_CTL);
  assign wr_max = access_done & pwrite & (hit == HIT_MAX);

  // Write data fields of the clock and control words.
  assign enable_field = pwdata[`CTL_EN_BIT];
  assign dir_field = pwdata[`CTL_DIR_MSB:`CTL_DIR_LSB];
  assign single_field = pwdata[`CTL_ONE_BIT];
  assign src_field = pwdata[`CLK_SRC_MSB:`CLK_SRC_LSB];
  assign div_field = pwdata[`CLK_DIV_MSB:`CLK_DIV_LSB];
  assign keep_field = pwdata[`CLK_DBG_BIT];

  // Control writes are refused while the module is disabled, except the enable bit itself.
  assign preset_req = wr_ctl & pwdata[`CTL_EN_BIT] & module_enable & pwdata[`CTL_PRESET_BIT];
  assign run_set = wr_ctl & pwdata[`CTL_EN_BIT] & module_enable & pwdata[`CTL_RUN_BIT];
  assign run_clear = wr_ctl & ~pwdata[`CTL_RUN_BIT];
  assign start_pulse = run_set & ~counter_active;

  assign tick_gate = module_enable & counter_active & (~debug_halt | keep_going_in_debug);

  count_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .gate(tick_gate),
    .start(start_pulse),
    .clock_source_select(clock_source_select),
    .clock_divider_select(clock_divider_select),
    .external_event_input(external_event_input),
    .tick(tick)
  );

  // An idle counter takes a new MAX at once; a running one only on its own count tick.
  max_update_sync u_max (
    .pclk(pclk),
    .presetn(presetn),
    .wr(wr_max),
    .wdata(pwdata[15:0]),
    .take((tick_gate & tick) | ~counter_active),
    .max_written(max_written),
    .max_active(max_active),
    .max_update_pending(max_update_pending)
  );

  // Next count, direction and activity for one count tick.
  always @* begin
    count_next = current_count;
    up_next = count_up;
    active_next = counter_active;
    case (count_direction_mode)
      `DIR_DOWN: begin
        up_next = 1'b0;
        if (current_count == `COUNT_ZERO) begin
          count_next = max_active;
          if (single_pass_select) begin
            active_next = 1'b0;
          end
        end else begin
          count_next = current_count - `COUNT_ONE;
        end
      end
      `DIR_UPDOWN: begin
        if (count_up) begin
          if (current_count > max_active) begin
            count_next = `COUNT_ZERO;
          end else if (current_count == max_active) begin
            up_next = 1'b0;
            if (max_active != `COUNT_ZERO) begin
              count_next = current_count - `COUNT_ONE;
            end
          end else begin
            count_next = current_count + `COUNT_ONE;
          end
        end else begin
          if (current_count == `COUNT_ZERO) begin
            if (single_pass_select) begin
              active_next = 1'b0;
            end else begin
              up_next = 1'b1;
              if (max_active != `COUNT_ZERO) begin
                count_next = `COUNT_ONE;
              end
            end
          end else begin
            count_next = current_count - `COUNT_ONE;
          end
        end
      end
      default: begin
        up_next = 1'b1;
        if (current_count >= max_active) begin
          count_next = `COUNT_ZERO;
          if (single_pass_select && current_count == max_active) begin
            active_next = 1'b0;
          end
        end else begin
          count_next = current_count + `COUNT_ONE;
        end
      end
    endcase
  end

  // Mode bits move only once the module is already enabled; the clock word is written whether or not it is.
  always @* begin
    clock_source_select_next = clock_source_select;
    clock_divider_select_next = clock_divider_select;
    keep_going_in_debug_next = keep_going_in_debug;
    module_enable_next = module_enable;
    count_direction_mode_next = count_direction_mode;
    single_pass_select_next = single_pass_select;
    if (wr_clk) begin
      clock_source_select_next = src_field;
      clock_divider_select_next = div_field;
      keep_going_in_debug_next = keep_field;
    end
    if (wr_ctl) begin
      module_enable_next = enable_field;
      if (module_enable) begin
        count_direction_mode_next = dir_field;
        single_pass_select_next = single_field;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_select <= `RST_SRC;
      clock_divider_select <= `RST_DIV;
      keep_going_in_debug <= 1'b0;
      module_enable <= 1'b0;
      count_direction_mode <= `DIR_UP;
      single_pass_select <= 1'b0;
    end else begin
      clock_source_select <= clock_source_select_next;
      clock_divider_select <= clock_divider_select_next;
      keep_going_in_debug <= keep_going_in_debug_next;
      module_enable <= module_enable_next;
      count_direction_mode <= count_direction_mode_next;
      single_pass_select <= single_pass_select_next;
    end
  end

  // Counter, direction and busy next values.
  always @* begin
    load_count_next = current_count;
    load_up_next = count_up;
    busy_next = counter_active;
    if (preset_req) begin
      if (dir_field == `DIR_DOWN) begin
        load_count_next = max_written;
        load_up_next = 1'b0;
      end else begin
        load_count_next = `COUNT_ZERO;
        load_up_next = 1'b1;
      end
    end else if (tick_gate && tick) begin
      load_count_next = count_next;
      load_up_next = up_next;
    end
    // A software run request wins over a one-shot stop in the same cycle.
    if (wr_ctl && !enable_field) begin
      busy_next = 1'b0;
    end else if (run_set) begin
      busy_next = 1'b1;
    end else if (run_clear) begin
      busy_next = 1'b0;
    end else if (tick_gate && tick) begin
      busy_next = active_next;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_count <= `COUNT_ZERO;
      count_up <= 1'b1;
      counter_active <= 1'b0;
    end else begin
      current_count <= load_count_next;
      count_up <= load_up_next;
      counter_active <= busy_next;
    end
  end

  // Register read mux.
  always @* begin
    rdata_next = 32'h00000000;
    case (hit)
      HIT_CLK: begin
        rdata_next[`CLK_SRC_MSB:`CLK_SRC_LSB] = clock_source_select;
        rdata_next[`CLK_DIV_MSB:`CLK_DIV_LSB] = clock_divider_select;
        rdata_next[`CLK_DBG_BIT] = keep_going_in_debug;
      end
      HIT_CTL: begin
        rdata_next[`CTL_EN_BIT] = module_enable;
        rdata_next[`CTL_RUN_BIT] = counter_active;
        rdata_next[`CTL_DIR_MSB:`CTL_DIR_LSB] = count_direction_mode;
        rdata_next[`CTL_ONE_BIT] = single_pass_select;
        rdata_next[`CTL_PEND_BIT] = max_update_pending;
      end
      HIT_MAX: begin
        rdata_next[15:0] = max_written;
      end
      HIT_CNT: begin
        rdata_next[15:0] = current_count;
      end
      HIT_STAT: begin
        rdata_next[`STAT_ACTIVE_BIT] = counter_active;
        rdata_next[`STAT_UP_BIT] = count_up;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // Fixed one-wait-free answer: pready rises in the access cycle that follows setup.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase & (hit == HIT_NONE);
      if (setup_phase) begin
        prdata <= rdata_next;
      end
    end
  end

endmodule

// file: test/updown_timer_counter_assertions.sv
// Port checker of the up/down timer counter.
`timescale 1ns/1ps
`include "timer_counter_defs.vh"
module updown_timer_counter_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire external_event_input,
  input wire debug_halt,
  input wire [15:0] current_count,
  input wire counter_active,
  input wire count_up
);
  reg keep_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keep_reg <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == `OFS_CLK) begin
      keep_reg <= pwdata[`CLK_DBG_BIT];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h00000000)
    else $error("bad error response");
  // Two halted cycles first: a tick launched just before halt may still land.
  chk_halt_freeze: assert property (debug_halt && $past(debug_halt) && $past(debug_halt, 2) && !keep_reg |->
    $stable(current_count)) else $error("count moved in halt");
  chk_up_step: assert property (counter_active && $past(counter_active) && count_up && $past(count_up) &&
    $changed(current_count) |-> current_count == $past(current_count) + 16'h0001 || current_count == 16'h0000)
    else $error("bad up step");
  chk_down_step: assert property (counter_active && $past(counter_active) && !count_up && !$past(count_up) &&
    $changed(current_count) |-> current_count == $past(current_count) - 16'h0001 || $past(current_count) == 16'h0000)
    else $error("bad down step");
  chk_idle_hold: assert property (!counter_active && !$past(counter_active) && !$past(counter_active, 2) &&
    !$past(psel && penable && pwrite) |-> $stable(current_count)) else $error("idle count moved");
  cov_run: cover property ($rose(counter_active));
  cov_down: cover property ($fell(count_up));
  cov_err: cover property (pslverr);
endmodule
bind updown_timer_counter_block updown_timer_counter_checker u_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .external_event_input(external_event_input), .debug_halt(debug_halt),
  .current_count(current_count), .counter_active(counter_active), .count_up(count_up));

// file: test/updown_timer_counter_block_tb.sv
// Self-checking testbench of the up/down timer counter.
`timescale 1ns/1ps
`include "timer_counter_defs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module updown_timer_counter_block_tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg external_event_input = 1'b0;
  reg debug_halt = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, counter_active, count_up;
  wire [15:0] current_count;
  int err_count = 0;
  int check_count = 0;
  int i;
  reg [31:0] rdat;
  reg rerr, one, u;
  reg [15:0] m, c;
  reg [1:0] md;
  updown_timer_counter_block u_updown_timer_counter_block (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_event_input(external_event_input), .debug_halt(debug_halt),
    .current_count(current_count), .counter_active(counter_active), .count_up(count_up));
  initial begin
    forever #25 pclk = ~pclk;
  end
  task results;
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task pend;
    int k;
    k = 0;
    do begin
      apb(1'b0, `OFS_CTL, 32'h0);
      k++;
    end while (rdat[`CTL_PEND_BIT] !== 1'b0 && k < 50);
    `CHK(rdat[`CTL_PEND_BIT], 1'b0)
  endtask
  function automatic [31:0] ctl(input reg run, input reg pre);
    ctl = 32'h1 << `CTL_EN_BIT | {31'h0, pre} << `CTL_PRESET_BIT | {31'h0, run} << `CTL_RUN_BIT |
      {30'h0, md} << `CTL_DIR_LSB | {31'h0, one} << `CTL_ONE_BIT;
  endfunction
  // Reference next count; u tracks the up/down phase on the bench side.
  function automatic [15:0] step(input reg [15:0] v);
    if (md == `DIR_UP) step = v >= m ? 16'h0000 : v + 16'h0001;
    else if (md == `DIR_DOWN) step = v == 16'h0000 ? m : v - 16'h0001;
    else begin
      if (u && v >= m) u = 1'b0;
      else if (!u && v == 16'h0000) u = 1'b1;
      step = u ? v + 16'h0001 : v - 16'h0001;
    end
  endfunction
  task watch(input int n);
    int k;
    k = 0;
    c = current_count;
    while (n > 0 && k < 4000) begin
      @(posedge pclk);
      k++;
      if (current_count !== c) begin
        `CHK(current_count, step(c))
        if (md != `DIR_UPDOWN) `CHK(count_up, md == `DIR_UP)
        c = current_count;
        n--;
      end
    end
    `CHK(n, 0)
  endtask
  task tog(input int n);
    repeat (n) begin
      external_event_input <= ~external_event_input;
      repeat (6) @(posedge pclk);
    end
  endtask
  initial begin
    #(50 * 40000);
    err_count++;
    results;
  end
  initial begin
    void'($urandom(58068));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({current_count, counter_active, count_up}, 18'h00001)
    apb(1'b0, `OFS_MAX, 32'h0);
    `CHK(rdat[15:0], `RST_MAX)
    apb(1'b0, 12'h014, 32'h0);
    `CHK({rerr, rdat}, 33'h100000000)
    md = `DIR_UP;
    one = 1'b0;
    apb(1'b1, `OFS_CTL, ctl(1'b1, 1'b0) & 32'hFFFFFFFE);
    apb(1'b0, `OFS_STAT, 32'h0);
    `CHK(rdat[`STAT_ACTIVE_BIT], 1'b0)
    for (i = 0; i < 6; i++) begin
      md = 2'(i % 3);
      one = i > 2;
      m = 16'h0002 + 16'($urandom % 5);
      apb(1'b1, `OFS_CLK, $urandom % 2 << `CLK_DIV_LSB);
      pend;
      apb(1'b1, `OFS_MAX, {16'h0, m});
      apb(1'b1, `OFS_CTL, ctl(1'b0, 1'b1));
      `CHK(current_count, md == `DIR_DOWN ? m : `COUNT_ZERO)
      u = md != `DIR_DOWN;
      apb(1'b1, `OFS_CTL, ctl(1'b1, 1'b0));
      watch(one ? (md == `DIR_UPDOWN ? 2 * int'(m) : int'(m) + 1) : 2 * int'(m) + 3);
      repeat (8) @(posedge pclk);
      `CHK(counter_active, ~one)
      if (one) `CHK(current_count, md == `DIR_DOWN ? m : `COUNT_ZERO)
      apb(1'b1, `OFS_CTL, ctl(1'b0, 1'b0));
    end
    md = `DIR_UP;
    one = 1'b0;
    m = 16'h0100;
    apb(1'b1, `OFS_CLK, 32'h0);
    apb(1'b1, `OFS_MAX, {16'h0, m});
    apb(1'b1, `OFS_CTL, ctl(1'b0, 1'b1));
    apb(1'b1, `OFS_CTL, ctl(1'b1, 1'b0));
    repeat (20) @(posedge pclk);
    debug_halt <= 1'b1;
    repeat (4) @(posedge pclk);
    c = current_count;
    repeat (20) @(posedge pclk);
    `CHK(current_count, c)
    apb(1'b1, `OFS_CLK, 32'h1 << `CLK_DBG_BIT);
    c = current_count;
    repeat (5) @(posedge pclk);
    `CHK(current_count !== c, 1'b1)
    debug_halt <= 1'b0;
    pend;
    m = 16'h0003;
    apb(1'b1, `OFS_MAX, {16'h0, m});
    pend;
    `CHK(current_count <= m, 1'b1)
    u = 1'b1;
    watch(6);
    for (i = 1; i < 3; i++) begin
      apb(1'b1, `OFS_CTL, ctl(1'b0, 1'b0));
      apb(1'b1, `OFS_CLK, 32'(i));
      apb(1'b1, `OFS_CTL, ctl(1'b0, 1'b1));
      apb(1'b1, `OFS_CTL, ctl(1'b1, 1'b0));
      tog(4);
      `CHK(current_count, `COUNT_ZERO)
      tog(1);
      `CHK(current_count, i == 1 ? 16'h0001 : 16'h0000)
      tog(1);
      `CHK(current_count, 16'h0001)
    end
    results;
  end
endmodule
